// ### rtl/das_params.svh
// register map, channel bit positions and reset values of the structure select block
`ifndef DAS_PARAMS_SVH
`define DAS_PARAMS_SVH
`define DAS_SET_ADDR 32'h40010030
`define DAS_CLR_ADDR 32'h40010034
`define DAS_SET_RESET 32'h00000000
`define DAS_CLR_RESET 32'h00000000
`define DAS_NUM_CH 14
`define DAS_CH_MASK 14'h38FF
`define DAS_BIT_SPI1_TX 0
`define DAS_BIT_SPI1_RX 1
`define DAS_BIT_UART_TX 2
`define DAS_BIT_UART_RX 3
`define DAS_BIT_TWI_S_TX 4
`define DAS_BIT_TWI_S_RX 5
`define DAS_BIT_TWI_M_TX 6
`define DAS_BIT_TWI_M_RX 7
`define DAS_BIT_ADC 11
`define DAS_BIT_SPI0_TX 12
`define DAS_BIT_SPI0_RX 13
`endif

// ### rtl/das_pkg.sv
// types shared by the structure select block
package das_pkg;
  typedef enum logic [2:0] {
    DAS_REG_NONE = 3'b001,
    DAS_REG_SET = 3'b010,
    DAS_REG_CLR = 3'b100
  } das_reg_t;
endpackage

// ### rtl/das_apb_decode.sv
// apb address decode for the set and clear registers
`timescale 1ns/1ps
`include "das_params.svh"
module das_apb_decode (
  input wire logic [31:0] paddr, // apb address
  output das_pkg::das_reg_t sel // selected register
);
  // match the two word addresses, anything else is unmapped
  always_comb
  begin
    if (paddr == `DAS_SET_ADDR)
      sel = das_pkg::DAS_REG_SET;
    else if (paddr == `DAS_CLR_ADDR)
      sel = das_pkg::DAS_REG_CLR;
    else
      sel = das_pkg::DAS_REG_NONE;
  end
endmodule

// ### rtl/das_sel_bit.sv
// one channel selection flop shared by the set and clear registers
`timescale 1ns/1ps
module das_sel_bit (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic sw_set, // software write of one to set register
  input wire logic sw_clr, // software write of one to clear register
  input wire logic hw_set, // controller selects alternate
  input wire logic hw_clr, // controller selects primary
  output logic alt_r // 1 while alternate structure in use
);
  // priority: software set, software clear, controller set, controller clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      alt_r <= 1'b0;
    else if (sw_set)
      alt_r <= 1'b1;
    else if (sw_clr)
      alt_r <= 1'b0;
    else if (hw_set)
      alt_r <= 1'b1;
    else if (hw_clr)
      alt_r <= 1'b0;
  end
endmodule

// ### rtl/das_alt_select.sv
// primary/alternate control structure select with apb set/clear registers
// Behaviour
// - set register read shows alternate use per channel
// - writing one to set selects alternate
// - writing zero to set changes nothing
// - uart rx/tx bits 3/2, spi1 rx/tx 1/0
// - clear register at 0x40010034, resets zero
// - writing one to clear selects primary
// - writing zero to clear changes nothing
// - spi0 13/12, adc 11, twi rx/tx 7/6
// - controller toggles selection for ping-pong, scatter-gather
// - set register at 0x40010030, resets zero
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "das_params.svh"
module das_alt_select #(
  parameter int NUM_CH = `DAS_NUM_CH
) (
  input wire logic clk, // system clock 250 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [NUM_CH-1:0] hw_alt_set, // controller selects alternate
  input wire logic [NUM_CH-1:0] hw_alt_clr, // controller selects primary
  output logic [NUM_CH-1:0] alt_sel // current selection per channel
);
  // position of every channel in both register words
  localparam int BIT_SECOND_SPI_TX = `DAS_BIT_SPI1_TX;
  localparam int BIT_SECOND_SPI_RX = `DAS_BIT_SPI1_RX;
  localparam int BIT_SERIAL_TX = `DAS_BIT_UART_TX;
  localparam int BIT_SERIAL_RX = `DAS_BIT_UART_RX;
  localparam int BIT_TWOWIRE_SLAVE_TX = `DAS_BIT_TWI_S_TX;
  localparam int BIT_TWOWIRE_SLAVE_RX = `DAS_BIT_TWI_S_RX;
  localparam int BIT_TWOWIRE_MASTER_TX = `DAS_BIT_TWI_M_TX;
  localparam int BIT_TWOWIRE_MASTER_RX = `DAS_BIT_TWI_M_RX;
  localparam int BIT_CONVERTER = `DAS_BIT_ADC;
  localparam int BIT_FIRST_SPI_TX = `DAS_BIT_SPI0_TX;
  localparam int BIT_FIRST_SPI_RX = `DAS_BIT_SPI0_RX;

  // implemented channels; every other position is reserved
  localparam logic [NUM_CH-1:0] CH_MASK = `DAS_CH_MASK;

  // the same set built from the channel positions, for the layout check
  localparam logic [31:0] CH_WORD = (32'h00000001 << BIT_SECOND_SPI_TX)
    | (32'h00000001 << BIT_SECOND_SPI_RX)
    | (32'h00000001 << BIT_SERIAL_TX)
    | (32'h00000001 << BIT_SERIAL_RX)
    | (32'h00000001 << BIT_TWOWIRE_SLAVE_TX)
    | (32'h00000001 << BIT_TWOWIRE_SLAVE_RX)
    | (32'h00000001 << BIT_TWOWIRE_MASTER_TX)
    | (32'h00000001 << BIT_TWOWIRE_MASTER_RX)
    | (32'h00000001 << BIT_CONVERTER)
    | (32'h00000001 << BIT_FIRST_SPI_TX)
    | (32'h00000001 << BIT_FIRST_SPI_RX);

  // reserved read-back bits above the channel field
  localparam int PAD_W = 32 - NUM_CH;

  // elaboration checks: refuse a layout that the logic cannot serve
  if (NUM_CH != `DAS_NUM_CH)
  begin : g_bad_num_ch
    $error("das_alt_select: NUM_CH must match the register layout");
  end
  if ((CH_WORD >> NUM_CH) != 32'h00000000)
  begin : g_bad_pos
    $error("das_alt_select: a channel position lies outside the channel field");
  end
  if (CH_WORD != 32'(CH_MASK))
  begin : g_bad_mask
    $error("das_alt_select: channel positions and implemented mask disagree");
  end

  das_pkg::das_reg_t sel; // register addressed by paddr
  logic setup_ph; // first cycle of a transfer
  logic access_ph; // second cycle, answered at once
  logic wr_set; // write of the set register, setup edge
  logic wr_clr; // write of the clear register, setup edge
  logic rd_set; // read of the set register, setup edge
  logic err_map; // addressed word is unmapped
  logic [NUM_CH-1:0] wdata_ch; // write data on implemented channels only
  logic [NUM_CH-1:0] sw_set_vec; // per-channel software select alternate
  logic [NUM_CH-1:0] sw_clr_vec; // per-channel software select primary
  logic [NUM_CH-1:0] alt_r; // selection flops, reserved bits tied low
  logic [31:0] prdata_nxt; // read data for the coming access phase
  logic [31:0] prdata_r; // read data register

  das_apb_decode u_dec (
    .paddr(paddr),
    .sel(sel)
  );

  // apb phases; registers act on the setup edge so a read right after a write sees it
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;

  // strobes for set write, clear write and set read, all taken at the setup edge
  assign wr_set = setup_ph && pwrite && (sel == das_pkg::DAS_REG_SET);
  assign wr_clr = setup_ph && pwrite && (sel == das_pkg::DAS_REG_CLR);
  assign rd_set = setup_ph && !pwrite && (sel == das_pkg::DAS_REG_SET);

  // per-channel software strobes; a zero bit leaves its channel alone
  assign wdata_ch = pwdata[NUM_CH-1:0] & CH_MASK;
  assign sw_set_vec = {NUM_CH{wr_set}} & wdata_ch;
  assign sw_clr_vec = {NUM_CH{wr_clr}} & wdata_ch;

  // one shared selection flop per implemented channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      if (CH_MASK[g])
      begin : g_impl
        das_sel_bit u_bit (
          .clk(clk),
          .resetn(resetn),
          .sw_set(sw_set_vec[g]),
          .sw_clr(sw_clr_vec[g]),
          .hw_set(hw_alt_set[g]),
          .hw_clr(hw_alt_clr[g]),
          .alt_r(alt_r[g])
        );
      end
      else
      begin : g_rsvd
        // reserved position: writes and controller requests are ignored
        assign alt_r[g] = 1'b0;
      end
    end
  endgenerate

  // next read data: the selection word at a set read, zero at any other setup
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (rd_set)
      prdata_nxt = {{PAD_W{1'b0}}, alt_r};
    else if (setup_ph)
      prdata_nxt = `DAS_CLR_RESET;
  end

  // read data register, stands through the access phase
  always_ff @(posedge clk)
  begin
    if (!resetn)
      prdata_r <= `DAS_SET_RESET;
    else
      prdata_r <= prdata_nxt;
  end

  // unmapped words answer with an error and change nothing
  always_comb
  begin
    case (sel)
      das_pkg::DAS_REG_SET: err_map = 1'b0;
      das_pkg::DAS_REG_CLR: err_map = 1'b0;
      default: err_map = 1'b1;
    endcase
  end

  assign alt_sel = alt_r;
  assign prdata = prdata_r;
  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = access_ph && err_map;
endmodule

// ### bench/das_alt_select_properties.sv
// concurrent checks on the ports of the structure select block
`timescale 1ns/1ps
`include "das_params.svh"
module das_alt_checker #(parameter int NUM_CH = 14) (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [NUM_CH-1:0] hw_alt_set, // controller selects alternate
  input wire logic [NUM_CH-1:0] hw_alt_clr, // controller selects primary
  input wire logic [NUM_CH-1:0] alt_sel // current selection per channel
);
  // setup-edge strobes for set write, clear write, set read and clear read
  wire logic ws = psel && !penable && pwrite && paddr == `DAS_SET_ADDR;
  wire logic wc = psel && !penable && pwrite && paddr == `DAS_CLR_ADDR;
  wire logic rs = psel && !penable && !pwrite && paddr == `DAS_SET_ADDR;
  wire logic rc = psel && !penable && !pwrite && paddr == `DAS_CLR_ADDR;
  // address outside both registers
  wire logic nm = paddr != `DAS_SET_ADDR && paddr != `DAS_CLR_ADDR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  set_one_a: assert property (ws && pwdata[3] |=> alt_sel[3])
    else $error("set write missed");
  set_zero_a: assert property (ws && !pwdata[0] && !hw_alt_set[0] && !hw_alt_clr[0]
    |=> $stable(alt_sel[0])) else $error("zero set write changed selection");
  clr_one_a: assert property (wc && pwdata[13] |=> !alt_sel[13])
    else $error("clear write missed");
  clr_zero_a: assert property (wc && !pwdata[11] && !hw_alt_set[11] && !hw_alt_clr[11]
    |=> $stable(alt_sel[11])) else $error("zero clear write changed selection");
  read_back_a: assert property (rs |=> prdata == 32'($past(alt_sel)))
    else $error("set read wrong");
  reserved_zero_a: assert property ((alt_sel & 14'h0700) == 14'h0000)
    else $error("reserved selection bit set");
  reset_clear_a: assert property (disable iff (1'b0) !resetn |=> alt_sel == '0)
    else $error("selection not cleared by reset");
  hw_switch_a: assert property (hw_alt_clr[1] && !hw_alt_set[1] && !psel |=> !alt_sel[1])
    else $error("controller clear missed");
  clr_read_a: assert property (rc |=> prdata == 32'h00000000)
    else $error("clear register read not zero");
  slverr_map_a: assert property (pslverr == (psel && penable && nm))
    else $error("error answer wrong for address");
  unmapped_a: assert property (psel && !penable && pwrite && nm && hw_alt_set == '0
    && hw_alt_clr == '0 |=> $stable(alt_sel)) else $error("unmapped write changed selection");
  ready_a: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  cover property (ws);
  cover property (wc);
  cover property (hw_alt_set != '0);
  cover property (psel && penable && nm);
endmodule
bind das_alt_select das_alt_checker #(.NUM_CH(NUM_CH)) i_das_alt_checker (
  .clk(clk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .hw_alt_set(hw_alt_set),
  .hw_alt_clr(hw_alt_clr),
  .alt_sel(alt_sel)
);

// ### bench/tb.sv
// register and controller switching tests of the structure select block
`timescale 1ns/1ps
module tb;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q;
  logic pready, pslverr, err;
  logic [13:0] hw_alt_set = 0, hw_alt_clr = 0, alt_sel;
  int n_fail = 0, compares = 0, cyc = 0;
  das_alt_select i_das_alt_select (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_alt_set(hw_alt_set), .hw_alt_clr(hw_alt_clr),
    .alt_sel(alt_sel));
  // 250 MHz clock
  always #2 clk = ~clk;
  task finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e)
      $display("Error %s exp %h seen %h", n, e, s);
    if (s !== e)
      n_fail++;
  endtask
  // one apb transfer, held until pready at a rising edge
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pulse the controller inputs for one cycle
  task hw(input logic [13:0] s, c);
    @(posedge clk) {hw_alt_set, hw_alt_clr} <= {s, c};
    @(posedge clk) {hw_alt_set, hw_alt_clr} <= 28'h0;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    xfer(0, 32'h40010030, 0); chk("set", q, 32'h0);
    xfer(1, 32'h40010030, 32'hFFFFFFFF); xfer(0, 32'h40010030, 0); chk("set", q, 32'h38FF);
    xfer(1, 32'h40010030, 0); xfer(0, 32'h40010030, 0); chk("set", q, 32'h38FF);
    xfer(1, 32'h40010034, 32'h2048); xfer(0, 32'h40010030, 0); chk("set", q, 32'h18B7);
    xfer(1, 32'h40010034, 0); xfer(0, 32'h40010030, 0); chk("set", q, 32'h18B7);
    xfer(0, 32'h40010034, 0); chk("clr", q, 32'h0); chk("clr_err", 32'(err), 32'h0);
    xfer(1, 32'h40010038, 32'hFFFFFFFF); chk("bad_err", 32'(err), 32'h1);
    xfer(0, 32'h40010038, 0); chk("bad_rd", q, 32'h0); chk("bad_err", 32'(err), 32'h1);
    xfer(0, 32'h40010030, 0); chk("set", q, 32'h18B7);
    $display("register test done");
    hw(14'h0, 14'h0803); chk("alt_sel", 32'(alt_sel), 32'h10B4);
    hw(14'h2008, 14'h0); chk("alt_sel", 32'(alt_sel), 32'h30BC);
    $display("controller test done");
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    xfer(0, 32'h40010030, 0); chk("set", q, 32'h0);
    $display("reset test done");
    finish_test;
  end
endmodule
